// file: hdl/cmr_pkg.sv
// constants, opcode patterns and decode helpers for the move/return decoder
package cmr_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FILE_AW = 7;
  localparam int unsigned SPEC_AW = 6;
  localparam int unsigned DEPTH_W = 4;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_PUSH = 8'h0c;

  // field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned ST_WREG_LSB = 0;
  localparam int unsigned ST_ZERO_BIT = 8;
  localparam int unsigned ST_UNDER_BIT = 9;
  localparam int unsigned ST_UNSUP_BIT = 10;
  localparam int unsigned ST_RUN_BIT = 11;
  localparam int unsigned ST_DEPTH_LSB = 12;
  localparam int unsigned DEST_BIT = 7;

  // values after reset
  localparam logic RUN_RST = 1'b0;
  localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;

  // opcode masks and patterns
  localparam logic [INSTR_W-1:0] MASK_OP6 = 14'h3f00;
  localparam logic [INSTR_W-1:0] MASK_OP7 = 14'h3f80;
  localparam logic [INSTR_W-1:0] MASK_OP8 = 14'h3fc0;
  localparam logic [INSTR_W-1:0] PAT_OR_WF = 14'h0400;
  localparam logic [INSTR_W-1:0] PAT_F2W = 14'h0800;
  localparam logic [INSTR_W-1:0] PAT_LIT = 14'h1900;
  localparam logic [INSTR_W-1:0] PAT_W2F = 14'h0080;
  localparam logic [INSTR_W-1:0] PAT_W2S = 14'h1e00;
  localparam logic [INSTR_W-1:0] PAT_S2W = 14'h1f00;
  localparam logic [INSTR_W-1:0] PAT_RET = 14'h0040;
  localparam logic [INSTR_W-1:0] PAT_NOP = 14'h0000;

  typedef enum {
    OP_NOP, OP_OR_WF, OP_F2W, OP_LIT, OP_W2F, OP_W2S, OP_S2W, OP_RET, OP_UNSUP
  } cmr_op_t;

  // one memory write request
  typedef struct packed {
    logic we;
    logic [FILE_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmr_wr_t;

  function automatic logic cmr_hit(input logic [INSTR_W-1:0] w,
                                   input logic [INSTR_W-1:0] m,
                                   input logic [INSTR_W-1:0] p);
    return (w & m) == p;
  endfunction

  function automatic cmr_op_t cmr_decode(input logic [INSTR_W-1:0] w);
    cmr_op_t op;
    op = OP_UNSUP;
    if (w == PAT_NOP) op = OP_NOP;
    else if (w == PAT_RET) op = OP_RET;
    else if (cmr_hit(w, MASK_OP6, PAT_OR_WF)) op = OP_OR_WF;
    else if (cmr_hit(w, MASK_OP7, PAT_F2W)) op = OP_F2W;
    else if (cmr_hit(w, MASK_OP6, PAT_LIT)) op = OP_LIT;
    else if (cmr_hit(w, MASK_OP7, PAT_W2F)) op = OP_W2F;
    else if (cmr_hit(w, MASK_OP8, PAT_W2S)) op = OP_W2S;
    else if (cmr_hit(w, MASK_OP8, PAT_S2W)) op = OP_S2W;
    return op;
  endfunction
endpackage

// file: hdl/cmr_mem.sv
// small register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module cmr_mem #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } cmr_mem_st_t;

  cmr_mem_st_t s_q, s_d;

  // read is not write-through; the core never reads and writes in one clock
  always_comb begin
    s_d = s_q;
    if (we) s_d.mem[waddr] = wdata;
    if (re) s_d.rdata = s_q.mem[raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign rdata = s_q.rdata;
endmodule
`default_nettype wire

// file: hdl/cmr_stack.sv
// hardware return stack, shift style, entry zero is the top
`timescale 1ns/100ps
`default_nettype none
module cmr_stack #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned W = 10,
  parameter int unsigned CW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] top,
  output logic [CW-1:0] depth
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [CW-1:0] cnt;
  } cmr_stk_st_t;

  cmr_stk_st_t s_q, s_d;

  // pop then push in one clock replaces the top; a full push drops the oldest
  always_comb begin
    s_d = s_q;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) s_d.ent[i] = s_q.ent[i+1];
      s_d.ent[DEPTH-1] = '0;
      if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;
    end
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) s_d.ent[i] = s_d.ent[i-1];
      s_d.ent[0] = push_data;
      if (s_d.cnt != CW'(DEPTH)) s_d.cnt = s_d.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign top = s_q.ent[0];
  assign depth = s_q.cnt;
endmodule
`default_nettype wire

// file: hdl/cmr_core.sv
// move/or/return decode and execute core with an apb control port
//
// Operation
// - or working register with file, set zero
// - destination bit: 0 to wreg, 1 to file
// - file operand is 7-bit address, 00h to 7fh
// - copy file to wreg, flags kept
// - load 8-bit literal into wreg, flags kept
// - copy wreg into file, flags kept
// - copy wreg into special register 00h-3fh
// - copy special register into wreg, flags kept
// - return pops stack into program counter
// - return takes two instruction cycles
`timescale 1ns/100ps
`default_nettype none
module cmr_core
  import cmr_pkg::*;
#(
  parameter int unsigned PC_W = 10,
  parameter int unsigned STACK_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [cmr_pkg::INSTR_W-1:0] prog_data,
  output logic [cmr_pkg::DATA_W-1:0] wreg,
  output logic zero_flag
);
  import cmr_pkg::*;

  typedef struct packed {
    logic run;
    logic phase;
    logic bubble;
    logic [INSTR_W-1:0] ir;
    logic [DATA_W-1:0] wreg;
    logic zero;
    logic under;
    logic unsup;
    logic [PC_W-1:0] pc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cmr_core_st_t;

  cmr_core_st_t s_q, s_d;
  cmr_op_t op;
  cmr_wr_t fwr;
  cmr_wr_t swr;
  logic stk_push;
  logic stk_pop;
  logic [PC_W-1:0] stk_top;
  logic [DEPTH_W-1:0] stk_depth;
  logic [DATA_W-1:0] file_rd;
  logic [DATA_W-1:0] spec_rd;
  logic [DATA_W-1:0] or_res;
  logic fetch;

  // operands are read while the word is fetched, used in the execute clock
  assign fetch = s_q.run && !s_q.phase;

  cmr_mem #(
    .AW(FILE_AW),
    .DW(DATA_W)
  ) u_file (
    .pclk(pclk),
    .presetn(presetn),
    .we(fwr.we),
    .waddr(fwr.addr),
    .wdata(fwr.data),
    .re(fetch),
    .raddr(prog_data[FILE_AW-1:0]),
    .rdata(file_rd)
  );

  cmr_mem #(
    .AW(SPEC_AW),
    .DW(DATA_W)
  ) u_spec (
    .pclk(pclk),
    .presetn(presetn),
    .we(swr.we),
    .waddr(swr.addr[SPEC_AW-1:0]),
    .wdata(swr.data),
    .re(fetch),
    .raddr(prog_data[SPEC_AW-1:0]),
    .rdata(spec_rd)
  );

  cmr_stack #(
    .DEPTH(STACK_DEPTH),
    .W(PC_W),
    .CW(DEPTH_W)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(stk_push),
    .push_data(pwdata[PC_W-1:0]),
    .pop(stk_pop),
    .top(stk_top),
    .depth(stk_depth)
  );

  // status word as software sees it
  function automatic logic [31:0] status_word(input cmr_core_st_t s,
                                               input logic [DEPTH_W-1:0] d);
    logic [31:0] r;
    r = '0;
    r[ST_WREG_LSB +: DATA_W] = s.wreg;
    r[ST_ZERO_BIT] = s.zero;
    r[ST_UNDER_BIT] = s.under;
    r[ST_UNSUP_BIT] = s.unsup;
    r[ST_RUN_BIT] = s.run;
    r[ST_DEPTH_LSB +: DEPTH_W] = d;
    return r;
  endfunction

  assign op = cmr_decode(s_q.ir);
  assign or_res = s_q.wreg | file_rd;

  always_comb begin
    s_d = s_q;
    fwr = '0;
    swr = '0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    s_d.pready = 1'b1;
    // setup phase: latch read data and error so the access phase has no wait
    if (psel && !penable) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (paddr == OFF_CTRL) begin
        s_d.prdata[CTRL_RUN_BIT] = s_q.run;
      end else if (paddr == OFF_STATUS) begin
        s_d.prdata = status_word(s_q, stk_depth);
      end else if (paddr == OFF_PC) begin
        s_d.prdata[PC_W-1:0] = s_q.pc;
      end else if (paddr == OFF_PUSH) begin
        s_d.prdata = '0;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // access phase writes; sticky bits are cleared here and may be set again below
    if (psel && penable && pwrite) begin
      if (paddr == OFF_CTRL) begin
        s_d.run = pwdata[CTRL_RUN_BIT];
      end else if (paddr == OFF_STATUS) begin
        if (pwdata[ST_UNDER_BIT]) s_d.under = 1'b0;
        if (pwdata[ST_UNSUP_BIT]) s_d.unsup = 1'b0;
      end else if (paddr == OFF_PC) begin
        // loading the counter while running would tear an instruction
        if (!s_q.run) s_d.pc = pwdata[PC_W-1:0];
      end else if (paddr == OFF_PUSH) begin
        stk_push = 1'b1;
      end
    end
    // two clocks per instruction cycle: fetch, then execute
    if (s_q.run) begin
      if (!s_q.phase) begin
        s_d.ir = prog_data;
        s_d.phase = 1'b1;
      end else begin
        s_d.phase = 1'b0;
        s_d.pc = s_q.pc + 1'b1;
        if (s_q.bubble) begin
          // second cycle of the return: the fetched word is discarded
          stk_pop = 1'b1;
          s_d.pc = stk_top;
          s_d.bubble = 1'b0;
          if (stk_depth == '0) s_d.under = 1'b1;
        end else begin
          case (op)
            OP_OR_WF: begin
              s_d.zero = (or_res == '0);
              if (s_q.ir[DEST_BIT]) begin
                fwr.we = 1'b1;
                fwr.addr = s_q.ir[FILE_AW-1:0];
                fwr.data = or_res;
              end else begin
                s_d.wreg = or_res;
              end
            end
            OP_F2W: begin
              s_d.wreg = file_rd;
            end
            OP_LIT: begin
              s_d.wreg = s_q.ir[DATA_W-1:0];
            end
            OP_W2F: begin
              fwr.we = 1'b1;
              fwr.addr = s_q.ir[FILE_AW-1:0];
              fwr.data = s_q.wreg;
            end
            OP_W2S: begin
              swr.we = 1'b1;
              swr.addr = FILE_AW'(s_q.ir[SPEC_AW-1:0]);
              swr.data = s_q.wreg;
            end
            OP_S2W: begin
              s_d.wreg = spec_rd;
            end
            OP_RET: begin
              // hold the counter; the jump happens in the next cycle
              s_d.pc = s_q.pc;
              s_d.bubble = 1'b1;
            end
            OP_NOP: begin
              s_d.bubble = 1'b0;
            end
            default: begin
              // unsupported words retire as no-operations and are flagged
              s_d.unsup = 1'b1;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.run <= RUN_RST;
      s_q.wreg <= WREG_RST;
      s_q.zero <= ZERO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign prog_addr = s_q.pc;
  assign wreg = s_q.wreg;
  assign zero_flag = s_q.zero;
endmodule
`default_nettype wire

// file: test/cmr_core_monitor.sv
// port checker for the move/or/return core
`timescale 1ns/100ps
`default_nettype none
module cmr_core_monitor
  import cmr_pkg::*;
#(
  parameter int unsigned PC_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [cmr_pkg::INSTR_W-1:0] prog_data,
  input wire logic [cmr_pkg::DATA_W-1:0] wreg,
  input wire logic zero_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // one full instruction cycle: pc moves, word fetched, pc moves again two clocks later
  sequence s_cyc(logic [13:0] m, logic [13:0] p);
    $changed(prog_addr) ##1 ((prog_data & m) == p) ##1 $changed(prog_addr);
  endsequence
  sequence s_ret;
    $changed(prog_addr) ##1 (prog_data == PAT_RET);
  endsequence

  // slave never stalls once out of reset
  chk_ready_up: assert property ($past(presetn) |-> pready) else $error("pready low");
  // a fetch address stands for both clocks of a cycle
  chk_addr_stands: assert property ($changed(prog_addr) |=> $stable(prog_addr))
    else $error("pc moved after one clock");
  chk_lit_load: assert property (s_cyc(MASK_OP6, PAT_LIT) |->
    wreg == $past(prog_data[7:0]) && $stable(zero_flag)) else $error("literal load wrong");
  chk_nop_idle: assert property (s_cyc(14'h3fff, PAT_NOP) |-> $stable(wreg) &&
    $stable(zero_flag) && prog_addr == $past(prog_addr) + 1'b1) else $error("nop changed state");
  chk_or_wreg: assert property (s_cyc(MASK_OP7, PAT_OR_WF) |->
    (wreg & $past(wreg)) == $past(wreg) && zero_flag == (wreg == 8'h00))
    else $error("or into wreg wrong");
  chk_or_file: assert property (s_cyc(MASK_OP7, PAT_OR_WF | 14'h0080) |->
    $stable(wreg) && (!zero_flag || wreg == 8'h00)) else $error("or into file wrong");
  chk_w2f_keep: assert property (s_cyc(MASK_OP7, PAT_W2F) |->
    $stable(wreg) && $stable(zero_flag)) else $error("copy to file changed wreg");
  chk_w2s_keep: assert property (s_cyc(MASK_OP8, PAT_W2S) |->
    $stable(wreg) && $stable(zero_flag)) else $error("copy to special changed wreg");
  chk_ret_hold: assert property (s_ret |=>
    ($stable(prog_addr) && $stable(wreg) && $stable(zero_flag))[*2])
    else $error("return finished early");
  // addresses past the last register answer with an error
  chk_bad_addr: assert property (psel && !penable && paddr > OFF_PUSH |=>
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
endmodule
bind cmr_core cmr_core_monitor #(.PC_W(PC_W)) u_cmr_core_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prog_addr(prog_addr), .prog_data(prog_data), .wreg(wreg), .zero_flag(zero_flag));
`default_nettype wire

// file: test/cmr_prog_model.sv
// program memory model: answers each address combinationally
`timescale 1ns/100ps
`default_nettype none
module cmr_prog_model #(
  parameter int unsigned AW = 10
) (
  input wire logic [AW-1:0] addr,
  output logic [13:0] data
);
  logic [13:0] mem [2**AW];
  // unwritten words hold the all-zero no-operation word
  initial foreach (mem[i]) mem[i] = 14'h0000;
  assign data = mem[addr];
endmodule
`default_nettype wire

// file: test/cmr_core_bench.sv
// self-checking bench for the move/or/return core
`timescale 1ns/100ps
`default_nettype none
module cmr_core_bench;
  import cmr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, zero_flag;
  logic [9:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0] wreg;
  logic [6:0] fa, fb;
  logic [5:0] ra;
  logic [13:0] img [13];
  int n_fail = 0, checked = 0, seed = 32'hae22, cyc;

  always #2 pclk = ~pclk;

  cmr_core u_cmr_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .wreg(wreg),
    .zero_flag(zero_flag));
  cmr_prog_model u_cmr_prog_model (.addr(prog_addr), .data(prog_data));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin n_fail++; summarize(); end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // wait for the pc to reach n; cyc holds the clocks spent
  // looked at on the falling edge so the flops launched at the rising edge have settled
  task automatic wait_pc(input logic [9:0] n);
    for (cyc = 1; cyc < 200; cyc++) begin
      @(negedge pclk);
      if (prog_addr === n) return;
    end
    n_fail++; summarize();
  endtask

  // reset, load a program around operands a and b, run it and watch results
  task automatic run_once(input logic [7:0] a, input logic [7:0] b);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    fa = {1'b0, 6'($random(seed))};
    fb = fa ^ 7'h01;
    ra = 6'($random(seed));
    img = '{PAT_LIT | 14'(a), PAT_W2F | 14'(fa), PAT_LIT | 14'(b), PAT_OR_WF | 14'(fa),
      PAT_W2S | 14'(ra), PAT_LIT, PAT_S2W | 14'(ra), PAT_F2W | 14'(fa), PAT_NOP,
      PAT_OR_WF | 14'h0080 | 14'(fb), PAT_LIT, PAT_OR_WF | 14'(fb), PAT_RET};
    for (int i = 0; i < 20; i++) u_cmr_prog_model.mem[i] = (i < 13) ? img[i] : 14'h0000;
    u_cmr_prog_model.mem[20] = PAT_LIT;
    u_cmr_prog_model.mem[21] = PAT_OR_WF | 14'h007f;
    u_cmr_prog_model.mem[22] = 14'h3fff; // unsupported word runs as nop
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, OFF_PUSH, 32'd20);
    apb(1'b0, 8'h10, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, pslverr}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    wait_pc(10'd4);
    cmp({zero_flag, wreg}, {(a | b) == 8'h00, a | b});
    wait_pc(10'd7);
    cmp(wreg, a | b);
    wait_pc(10'd8);
    cmp(wreg, a);
    wait_pc(10'd12);
    cmp({zero_flag, wreg}, {a == 8'h00, a});
    wait_pc(10'd20);
    cmp(cyc, 4);
    wait_pc(10'd24);
    cmp({zero_flag, wreg}, {1'b1, 8'h00});
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0000_0500);
    // counter load is only taken while halted
    apb(1'b1, OFF_PC, 32'h3ff);
    apb(1'b0, OFF_PC, 32'h0);
    cmp(rd, 32'h0000_03ff);
  endtask

  initial begin
    run_once(8'h00, 8'h00);
    repeat (3) run_once(8'($random(seed)), 8'($random(seed)));
    summarize();
  end
endmodule
`default_nettype wire
